// *** src/rta_pkg.sv ***
// constants shared by the result transfer and alert logic
// Overview of operation
// RQ1: normally all results load into result registers together when an acquisition ends.
// RQ2: every copy into result registers sets results_ready_flag.
// RQ3: host starts, polls done flag, reads results, then repeats.
// RQ4: acquisition_done_flag sets at acquisition end; start strobe reads zero.
// RQ5: with double_buffer_enable set, the automatic copy waits until the next start.
// RQ6: in double-buffer mode manual_transfer_strobe forces the copy.
// RQ7: manual transfer is ignored during an acquisition; host checks done first.
// RQ8: alerts update before any result copy happens.
// RQ9: with oversampling, alerts update once after the final averaged oversample.
// RQ10: alerts update regardless of copying, only for enabled measurements.
// RQ11: enabled cell over-voltage flag sets when voltage strictly above set threshold.
// RQ12: enabled cell under-voltage flag sets when voltage strictly below set threshold.
// RQ13: over flag clears strictly below clear level; under flag strictly above.
// RQ14: voltage equal to any threshold leaves the flag unchanged.
// RQ15: summaries OR all flags; per-cell any-alert ORs over and under.
// RQ16: enabled mismatch alert sets when max minus min exceeds threshold.
// RQ17: mismatch alert clears after an acquisition not exceeding the threshold.
// RQ18: mismatch threshold resets to FFCH, which disables the alert; the code resets it to FFFCh (MISMATCH_RST).
// RQ19: record min and max cell positions; ties report the highest position.
// RQ20: store 16-bit sum of enabled cell voltages after each acquisition.
// RQ21: with no enabled cells, index and total stay unchanged.
// RQ22: enabled aux input above cold level sets cold; below hot level sets hot.
// RQ23: temperature alerts use one threshold per direction, no hysteresis.
// RQ24: a temperature flag clears once the voltage is back within its threshold.
package rta_pkg;
	localparam int ADDR_W = 8;
	localparam int RES_W = 16;
	localparam int CELL_COUNT = 12;
	localparam int AUX_COUNT = 2;
	localparam int IDX_W = 4;
	// byte addresses of the register map
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] MEASEN_OFS = 8'h08;
	localparam logic [7:0] OVEN_OFS = 8'h0C;
	localparam logic [7:0] UVEN_OFS = 8'h10;
	localparam logic [7:0] OVSET_OFS = 8'h14;
	localparam logic [7:0] OVCLR_OFS = 8'h18;
	localparam logic [7:0] UVSET_OFS = 8'h1C;
	localparam logic [7:0] UVCLR_OFS = 8'h20;
	localparam logic [7:0] MISMATCH_OFS = 8'h24;
	localparam logic [7:0] AUXHOT_OFS = 8'h28;
	localparam logic [7:0] AUXCOLD_OFS = 8'h2C;
	localparam logic [7:0] OVFLAGS_OFS = 8'h30;
	localparam logic [7:0] UVFLAGS_OFS = 8'h34;
	localparam logic [7:0] ANYALERT_OFS = 8'h38;
	localparam logic [7:0] EXTREME_OFS = 8'h3C;
	localparam logic [7:0] TOTAL_OFS = 8'h40;
	localparam logic [7:0] BLOCK_OFS = 8'h44;
	localparam logic [7:0] AUX1_OFS = 8'h48;
	localparam logic [7:0] AUX2_OFS = 8'h4C;
	localparam logic [7:0] SELFTEST_RESULT_OFS = 8'h50;
	localparam logic [7:0] CELL0_OFS = 8'h80;
	// control register bits
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_MOVE_BIT = 1;
	localparam int CTRL_DBL_BIT = 2;
	localparam int CTRL_ALT_BIT = 3;
	localparam int CTRL_MMEN_BIT = 4;
	// status register bits
	localparam int ST_DONE_BIT = 0;
	localparam int ST_READY_BIT = 1;
	localparam int ST_OV_BIT = 2;
	localparam int ST_UV_BIT = 3;
	localparam int ST_MM_BIT = 4;
	localparam int ST_HOT_BIT = 5;
	localparam int ST_COLD_BIT = 6;
	localparam int ST_BUSY_BIT = 7;
	// measurement enable bits above the cell bits
	localparam int MEAS_BLOCK_BIT = 12;
	localparam int MEAS_AUX0_BIT = 13;
	localparam int MEAS_SELFTEST_RESULT_BIT = 15;
	// aux enables sit above the cell bits in the alert enables
	localparam int ALERT_AUX0_BIT = 12;
	// values after reset
	localparam logic [15:0] MISMATCH_RST = 16'hFFFC;
	localparam logic [15:0] THR_RST = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rta_pkg

// *** src/cell_stats.sv ***
// minimum, maximum, their positions and the sum over enabled cells
`timescale 1ns/100ps
module cell_stats import rta_pkg::*; #(
	parameter int NUM_CELLS = CELL_COUNT
) (
	// cell results and enables
	input wire logic [NUM_CELLS*RES_W-1:0] cells,
	input wire logic [NUM_CELLS-1:0] enables,
	// statistics
	output logic [IDX_W-1:0] minIdx,
	output logic [IDX_W-1:0] maxIdx,
	output logic [RES_W-1:0] minVal,
	output logic [RES_W-1:0] maxVal,
	output logic [RES_W-1:0] total,
	output logic anyEnabled
);
	// ascending scan with inclusive compare so ties land on the highest position
	always_comb begin
		logic [RES_W-1:0] v;
		v = '0;
		minIdx = '0;
		maxIdx = '0;
		minVal = 16'hFFFF;
		maxVal = 16'h0000;
		total = '0;
		anyEnabled = 1'b0;
		for (int i = 0; i < NUM_CELLS; i++) begin
			v = cells[i*RES_W +: RES_W];
			if (enables[i]) begin
				if (!anyEnabled || v <= minVal) begin // [RQ19]
					minVal = v;
					minIdx = IDX_W'(i + 1);
				end
				if (!anyEnabled || v >= maxVal) begin // [RQ19]
					maxVal = v;
					maxIdx = IDX_W'(i + 1);
				end
				total = RES_W'(total + v); // sum wraps at 16 bits [RQ20]
				anyEnabled = 1'b1;
			end
		end
	end
endmodule : cell_stats

// *** src/result_transfer_and_alerts.sv ***
// result transfer, double buffering and threshold alerts behind an axi4-lite slave
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module result_transfer_and_alerts import rta_pkg::*; #(
	parameter int NUM_CELLS = CELL_COUNT
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// axi4-lite write address and data
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// acquisition sequencer events and arithmetic unit results
	input wire logic acqBegin,
	input wire logic acqEnd,
	input wire logic [NUM_CELLS*RES_W-1:0] aluCells,
	input wire logic [RES_W-1:0] aluBlock,
	input wire logic [RES_W-1:0] aluAux1,
	input wire logic [RES_W-1:0] aluAux2,
	input wire logic [RES_W-1:0] aluDiag,
	// request to the sequencer
	output logic startAcq
);
	// positions are four bits wide and cell registers must fit the map
	if (NUM_CELLS < 1 || NUM_CELLS > 12) begin : g_check
		$error("NUM_CELLS must be 1 to 12");
	end

	// write channel state
	logic awready_ff, wready_ff, bvalid_ff;
	logic [1:0] bresp_ff;
	logic awHave_ff, wHave_ff;
	logic [ADDR_W-1:0] awAddr_ff;
	logic [31:0] wData_ff;
	logic [3:0] wStrb_ff;
	// read channel state
	logic arready_ff, rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	// configuration
	logic dblBuf_ff, altBuf_ff, mmEn_ff;
	logic [15:0] measEn_ff, ovEn_ff, uvEn_ff;
	logic [15:0] ovSet_ff, ovClr_ff, uvSet_ff, uvClr_ff;
	logic [15:0] mmThr_ff, auxHot_ff, auxCold_ff;
	// status and sequencing
	logic startAcq_ff, busy_ff, done_ff, ready_ff, copyLate_ff;
	logic mmAlert_ff;
	// statistics held until the copy, and the result registers
	logic [IDX_W-1:0] aluMinIdx_ff, aluMaxIdx_ff;
	logic [RES_W-1:0] aluTotal_ff;
	logic [RES_W-1:0] cellData_ff [NUM_CELLS];
	logic [RES_W-1:0] blockData_ff, aux1Data_ff, aux2Data_ff, diagData_ff;
	logic [IDX_W-1:0] minData_ff, maxData_ff;
	logic [RES_W-1:0] totalData_ff;
	// combinational helpers
	logic doWrite, writeOk, copyNow, manualXfer;
	logic [31:0] wMasked;
	logic [31:0] rdMux;
	logic rdOk;
	logic [NUM_CELLS-1:0] ovFlags, uvFlags;
	logic [AUX_COUNT-1:0] auxHigh, auxLow;
	logic [IDX_W-1:0] stMinIdx, stMaxIdx;
	logic [RES_W-1:0] stMin, stMax, stTotal;
	logic stAny;

	assign awready = awready_ff;
	assign wready = wready_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign arready = arready_ff;
	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;
	assign startAcq = startAcq_ff;

	// a write completes once both address and data are held
	assign doWrite = awHave_ff && wHave_ff && !bvalid_ff;
	// byte enables pick lanes from new data, the rest comes as zero
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wMasked[b*8 +: 8] = wStrb_ff[b] ? wData_ff[b*8 +: 8] : 8'h00;
		end
	end

	// only configuration, control and status offsets accept writes
	always_comb begin
		case (awAddr_ff)
			CTRL_OFS, STATUS_OFS, MEASEN_OFS, OVEN_OFS, UVEN_OFS,
			OVSET_OFS, OVCLR_OFS, UVSET_OFS, UVCLR_OFS, MISMATCH_OFS,
			AUXHOT_OFS, AUXCOLD_OFS: writeOk = 1'b1;
			default: writeOk = 1'b0;
		endcase
	end

	// address and data are taken independently, in either order
	always_ff @(posedge clock) begin
		if (rst) begin
			awready_ff <= 1'b0;
			awHave_ff <= 1'b0;
			awAddr_ff <= '0;
		end else if (awvalid && awready_ff) begin
			awready_ff <= 1'b0;
			awHave_ff <= 1'b1;
			awAddr_ff <= {awaddr[ADDR_W-1:2], 2'b00};
		end else begin
			if (doWrite) awHave_ff <= 1'b0;
			if (!awHave_ff && !bvalid_ff) awready_ff <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wready_ff <= 1'b0;
			wHave_ff <= 1'b0;
			wData_ff <= '0;
			wStrb_ff <= '0;
		end else if (wvalid && wready_ff) begin
			wready_ff <= 1'b0;
			wHave_ff <= 1'b1;
			wData_ff <= wdata;
			wStrb_ff <= wstrb;
		end else begin
			if (doWrite) wHave_ff <= 1'b0;
			if (!wHave_ff && !bvalid_ff) wready_ff <= 1'b1;
		end
	end

	// response follows both halves; unmapped offsets answer slverr
	always_ff @(posedge clock) begin
		if (rst) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else if (doWrite) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= writeOk ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_ff && bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// configuration registers, written with byte enables
	always_ff @(posedge clock) begin
		if (rst) begin
			dblBuf_ff <= 1'b0;
			altBuf_ff <= 1'b0;
			mmEn_ff <= 1'b0;
			measEn_ff <= '0;
			ovEn_ff <= '0;
			uvEn_ff <= '0;
			ovSet_ff <= THR_RST;
			ovClr_ff <= THR_RST;
			uvSet_ff <= THR_RST;
			uvClr_ff <= THR_RST;
			mmThr_ff <= MISMATCH_RST; // alert effectively off [RQ18]
			auxHot_ff <= THR_RST;
			auxCold_ff <= THR_RST;
		end else if (doWrite) begin
			case (awAddr_ff)
				CTRL_OFS: begin
					if (wStrb_ff[0]) begin
						dblBuf_ff <= wData_ff[CTRL_DBL_BIT];
						altBuf_ff <= wData_ff[CTRL_ALT_BIT];
						mmEn_ff <= wData_ff[CTRL_MMEN_BIT];
					end
				end
				MEASEN_OFS: measEn_ff <= wMasked[15:0] | (measEn_ff & ~{{8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}});
				OVEN_OFS: ovEn_ff <= wMasked[15:0] | (ovEn_ff & ~{{8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}});
				UVEN_OFS: uvEn_ff <= wMasked[15:0] | (uvEn_ff & ~{{8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}});
				OVSET_OFS: ovSet_ff <= wMasked[15:0] | (ovSet_ff & ~{{8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}});
				OVCLR_OFS: ovClr_ff <= wMasked[15:0] | (ovClr_ff & ~{{8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}});
				UVSET_OFS: uvSet_ff <= wMasked[15:0] | (uvSet_ff & ~{{8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}});
				UVCLR_OFS: uvClr_ff <= wMasked[15:0] | (uvClr_ff & ~{{8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}});
				MISMATCH_OFS: mmThr_ff <= wMasked[15:0] | (mmThr_ff & ~{{8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}}); // [RQ18]
				AUXHOT_OFS: auxHot_ff <= wMasked[15:0] | (auxHot_ff & ~{{8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}});
				AUXCOLD_OFS: auxCold_ff <= wMasked[15:0] | (auxCold_ff & ~{{8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}});
				default: ;
			endcase
		end
	end

	// start is a one-cycle strobe to the sequencer, never stored [RQ4]
	always_ff @(posedge clock) begin
		if (rst) startAcq_ff <= 1'b0;
		else startAcq_ff <= doWrite && awAddr_ff == CTRL_OFS && wMasked[CTRL_START_BIT];
	end

	// busy from the start request until the sequencer reports the end
	always_ff @(posedge clock) begin
		if (rst) busy_ff <= 1'b0;
		else if (acqEnd) busy_ff <= 1'b0;
		else if (doWrite && awAddr_ff == CTRL_OFS && wMasked[CTRL_START_BIT]) busy_ff <= 1'b1;
	end

	// done sets at the end; the start write clears it in the edge busy sets, so the
	// two never read back together; the end wins a tie
	always_ff @(posedge clock) begin
		if (rst) done_ff <= 1'b0;
		else if (acqEnd) done_ff <= 1'b1; // [RQ4]
		else if (doWrite && awAddr_ff == CTRL_OFS && wMasked[CTRL_START_BIT]) done_ff <= 1'b0;
	end

	// manual copy only in double-buffer mode and never mid-acquisition
	assign manualXfer = doWrite && awAddr_ff == CTRL_OFS && wMasked[CTRL_MOVE_BIT] && dblBuf_ff
		&& !busy_ff && !acqBegin; // [RQ6] [RQ7]

	// the automatic copy trails the alert update by one cycle [RQ8]
	always_ff @(posedge clock) begin
		if (rst) copyLate_ff <= 1'b0;
		else copyLate_ff <= acqEnd && !dblBuf_ff;
	end

	// double buffering defers the copy to the next acquisition start [RQ1] [RQ5]
	assign copyNow = copyLate_ff || (acqBegin && dblBuf_ff) || manualXfer;

	// ready sets on every copy; software clears by writing one, set wins
	always_ff @(posedge clock) begin
		if (rst) ready_ff <= 1'b0;
		else if (copyNow) ready_ff <= 1'b1; // [RQ2]
		else if (doWrite && awAddr_ff == STATUS_OFS && wMasked[ST_READY_BIT]) ready_ff <= 1'b0;
	end

	// all result registers load in the same edge
	always_ff @(posedge clock) begin
		if (rst) begin
			for (int i = 0; i < NUM_CELLS; i++) cellData_ff[i] <= '0;
			blockData_ff <= '0;
			aux1Data_ff <= '0;
			aux2Data_ff <= '0;
			diagData_ff <= '0;
			minData_ff <= '0;
			maxData_ff <= '0;
			totalData_ff <= '0;
		end else if (copyNow) begin // [RQ1]
			for (int i = 0; i < NUM_CELLS; i++) cellData_ff[i] <= aluCells[i*RES_W +: RES_W];
			blockData_ff <= aluBlock;
			aux1Data_ff <= aluAux1;
			aux2Data_ff <= aluAux2;
			diagData_ff <= aluDiag;
			minData_ff <= aluMinIdx_ff;
			maxData_ff <= aluMaxIdx_ff;
			totalData_ff <= aluTotal_ff;
		end
	end

	cell_stats #(.NUM_CELLS(NUM_CELLS)) u_stats (
		.cells(aluCells),
		.enables(measEn_ff[NUM_CELLS-1:0]),
		.minIdx(stMinIdx),
		.maxIdx(stMaxIdx),
		.minVal(stMin),
		.maxVal(stMax),
		.total(stTotal),
		.anyEnabled(stAny)
	);

	// statistics wait beside the alu results until the copy
	always_ff @(posedge clock) begin
		if (rst) begin
			aluMinIdx_ff <= '0;
			aluMaxIdx_ff <= '0;
			aluTotal_ff <= '0;
		end else if (acqEnd && stAny) begin // no enabled cell keeps old values [RQ21]
			aluMinIdx_ff <= stMinIdx; // [RQ19]
			aluMaxIdx_ff <= stMaxIdx;
			aluTotal_ff <= stTotal; // [RQ20]
		end
	end

	// mismatch judged afresh each acquisition with an enabled cell; off when disabled
	always_ff @(posedge clock) begin
		if (rst) mmAlert_ff <= 1'b0;
		else if (acqEnd && stAny) mmAlert_ff <= mmEn_ff && (stMax - stMin) > mmThr_ff; // [RQ16] [RQ17]
		else if (!mmEn_ff) mmAlert_ff <= 1'b0;
	end

	// per-cell hysteresis; acqEnd follows the last averaged oversample [RQ9] [RQ10]
	for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
		logic ovBit_ff, uvBit_ff;
		logic [RES_W-1:0] v;
		assign v = aluCells[c*RES_W +: RES_W];
		always_ff @(posedge clock) begin
			if (rst) ovBit_ff <= 1'b0;
			else if (acqEnd && measEn_ff[c] && ovEn_ff[c]) begin
				if (v > ovSet_ff) ovBit_ff <= 1'b1; // [RQ11] [RQ14]
				else if (v < ovClr_ff) ovBit_ff <= 1'b0; // [RQ13] [RQ14]
			end
		end
		always_ff @(posedge clock) begin
			if (rst) uvBit_ff <= 1'b0;
			else if (acqEnd && measEn_ff[c] && uvEn_ff[c]) begin
				if (v < uvSet_ff) uvBit_ff <= 1'b1; // [RQ12] [RQ14]
				else if (v > uvClr_ff) uvBit_ff <= 1'b0; // [RQ13] [RQ14]
			end
		end
		assign ovFlags[c] = ovBit_ff;
		assign uvFlags[c] = uvBit_ff;
	end

	// aux inputs: one threshold each way, so enabled flags follow every acquisition [RQ23]
	for (genvar a = 0; a < AUX_COUNT; a++) begin : g_aux
		logic highBit_ff, lowBit_ff;
		logic [RES_W-1:0] v;
		logic upd;
		assign v = (a == 0) ? aluAux1 : aluAux2;
		assign upd = acqEnd && measEn_ff[MEAS_AUX0_BIT + a];
		always_ff @(posedge clock) begin
			if (rst) highBit_ff <= 1'b0;
			else if (upd && ovEn_ff[ALERT_AUX0_BIT + a]) highBit_ff <= v > auxCold_ff; // [RQ22] [RQ24]
		end
		always_ff @(posedge clock) begin
			if (rst) lowBit_ff <= 1'b0;
			else if (upd && uvEn_ff[ALERT_AUX0_BIT + a]) lowBit_ff <= v < auxHot_ff; // [RQ22] [RQ24]
		end
		assign auxHigh[a] = highBit_ff;
		assign auxLow[a] = lowBit_ff;
	end

	// read decode; summaries are ORs of the flag registers
	always_comb begin
		rdMux = '0;
		rdOk = 1'b1;
		case ({araddr[ADDR_W-1:2], 2'b00})
			CTRL_OFS: begin
				rdMux[CTRL_DBL_BIT] = dblBuf_ff;
				rdMux[CTRL_ALT_BIT] = altBuf_ff;
				rdMux[CTRL_MMEN_BIT] = mmEn_ff; // strobes read as zero [RQ4]
			end
			STATUS_OFS: begin
				rdMux[ST_DONE_BIT] = done_ff;
				rdMux[ST_READY_BIT] = ready_ff;
				rdMux[ST_OV_BIT] = |ovFlags; // [RQ15]
				rdMux[ST_UV_BIT] = |uvFlags; // [RQ15]
				rdMux[ST_MM_BIT] = mmAlert_ff;
				rdMux[ST_HOT_BIT] = |auxLow; // [RQ22]
				rdMux[ST_COLD_BIT] = |auxHigh; // [RQ22]
				rdMux[ST_BUSY_BIT] = busy_ff;
			end
			MEASEN_OFS: rdMux[15:0] = measEn_ff;
			OVEN_OFS: rdMux[15:0] = ovEn_ff;
			UVEN_OFS: rdMux[15:0] = uvEn_ff;
			OVSET_OFS: rdMux[15:0] = ovSet_ff;
			OVCLR_OFS: rdMux[15:0] = ovClr_ff;
			UVSET_OFS: rdMux[15:0] = uvSet_ff;
			UVCLR_OFS: rdMux[15:0] = uvClr_ff;
			MISMATCH_OFS: rdMux[15:0] = mmThr_ff;
			AUXHOT_OFS: rdMux[15:0] = auxHot_ff;
			AUXCOLD_OFS: rdMux[15:0] = auxCold_ff;
			OVFLAGS_OFS: begin
				rdMux[NUM_CELLS-1:0] = ovFlags;
				rdMux[ALERT_AUX0_BIT +: AUX_COUNT] = auxHigh;
			end
			UVFLAGS_OFS: begin
				rdMux[NUM_CELLS-1:0] = uvFlags;
				rdMux[ALERT_AUX0_BIT +: AUX_COUNT] = auxLow;
			end
			ANYALERT_OFS: rdMux[NUM_CELLS-1:0] = ovFlags | uvFlags; // [RQ15]
			EXTREME_OFS: begin
				rdMux[IDX_W-1:0] = minData_ff;
				rdMux[8 +: IDX_W] = maxData_ff;
			end
			TOTAL_OFS: rdMux[15:0] = totalData_ff;
			BLOCK_OFS: rdMux[15:0] = blockData_ff;
			AUX1_OFS: rdMux[15:0] = aux1Data_ff;
			AUX2_OFS: rdMux[15:0] = aux2Data_ff;
			SELFTEST_RESULT_OFS: rdMux[15:0] = diagData_ff;
			default: begin
				if (araddr >= CELL0_OFS && araddr[ADDR_W-1:2] - CELL0_OFS[ADDR_W-1:2]
					< 6'(NUM_CELLS)) begin
					rdMux[15:0] = cellData_ff[IDX_W'(araddr[ADDR_W-1:2] - CELL0_OFS[ADDR_W-1:2])];
				end else begin
					rdOk = 1'b0;
				end
			end
		endcase
	end

	// one read in flight; data follows the address by one cycle
	always_ff @(posedge clock) begin
		if (rst) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= RESP_OKAY;
		end else if (arvalid && arready_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rdata_ff <= rdMux;
			rresp_ff <= rdOk ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_ff && rready) begin
			rvalid_ff <= 1'b0;
		end else if (!rvalid_ff) begin
			arready_ff <= 1'b1;
		end
	end
endmodule : result_transfer_and_alerts

// *** dv/result_transfer_and_alerts_assertions.sv ***
// port-level checks of the register bus and start request
`timescale 1ns/100ps
module result_transfer_and_alerts_assertions import rta_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	// sequencer request
	input wire logic startAcq
);
	logic [ADDR_W-1:0] rdAddr_ff;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// address of the read being answered
	always_ff @(posedge clock) begin
		if (arvalid && arready) rdAddr_ff <= araddr;
	end
	sequence s_arTaken; arvalid && arready; endsequence
	sequence s_wrTaken; awvalid && awready && wvalid && wready; endsequence
	property p_startPulse; startAcq |=> !startAcq; endproperty
	a_startPulse: assert property (p_startPulse) else $error("start pulse too long");
	property p_startCause; startAcq |-> $rose(bvalid); endproperty
	a_startCause: assert property (p_startCause) else $error("start without write");
	property p_readAnswer; s_arTaken |=> rvalid && !arready; endproperty
	a_readAnswer: assert property (p_readAnswer) else $error("read answer late");
	property p_writeAnswer; s_wrTaken |=> !awready && !wready ##1 bvalid; endproperty
	a_writeAnswer: assert property (p_writeAnswer) else $error("write answer late");
	property p_readRecover; rvalid && rready |=> !rvalid ##[0:2] arready; endproperty
	a_readRecover: assert property (p_readRecover) else $error("read not released");
	property p_bRecover; bvalid && bready |=> !bvalid ##[0:2] (awready && wready); endproperty
	a_bRecover: assert property (p_bRecover) else $error("write not released");
	property p_ctrlZero; rvalid && rdAddr_ff == CTRL_OFS |-> rdata[1:0] == 2'h0; endproperty
	a_ctrlZero: assert property (p_ctrlZero) else $error("strobe reads one");
	property p_busyDone;
		rvalid && rdAddr_ff == STATUS_OFS |-> !(rdata[ST_BUSY_BIT] && rdata[ST_DONE_BIT]);
	endproperty
	a_busyDone: assert property (p_busyDone) else $error("busy and done together");
	property p_unmappedZero; rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0; endproperty
	a_unmappedZero: assert property (p_unmappedZero) else $error("error read data");
	property p_upperZero; rvalid |-> rdata[31:16] == 16'h0; endproperty
	a_upperZero: assert property (p_upperZero) else $error("upper bits set");
endmodule : result_transfer_and_alerts_assertions

// *** dv/acq_sequencer_model.sv ***
// sequencer stand-in: start request to begin and end pulses
`timescale 1ns/100ps
module acq_sequencer_model (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// request from the block and pacing choice
	input wire logic startAcq,
	input wire logic slow,
	// acquisition events
	output logic acqBegin,
	output logic acqEnd
);
	logic [1:0] phase_ff;
	logic [7:0] wait_ff;
	// slow pacing leaves room for host traffic inside an acquisition
	always_ff @(posedge clock) begin
		acqBegin <= 1'b0;
		acqEnd <= 1'b0;
		if (rst) begin
			phase_ff <= 2'h0;
			wait_ff <= 8'h0;
		end else if (startAcq) begin
			phase_ff <= 2'h1;
			wait_ff <= slow ? 8'h06 : 8'h01;
		end else if (wait_ff != 8'h0) begin
			wait_ff <= wait_ff - 8'h1;
		end else if (phase_ff == 2'h1) begin
			acqBegin <= 1'b1;
			phase_ff <= 2'h2;
			wait_ff <= slow ? 8'h3C : 8'h03;
		end else if (phase_ff == 2'h2) begin
			acqEnd <= 1'b1; // one end pulse after the last averaged sample
			phase_ff <= 2'h0;
		end
	end
endmodule : acq_sequencer_model

// *** dv/result_transfer_and_alerts_tb.sv ***
// self-checking bench for the result transfer and alert block
`timescale 1ns/100ps
module result_transfer_and_alerts_tb import rta_pkg::*; ();
	localparam logic [15:0] OVS = 16'h3000, OVC = 16'h2000, UVS = 16'h1000, UVC = 16'h1800;
	localparam logic [15:0] HOT = 16'h0800, COLD = 16'h3800, MMT = 16'h2000;
	logic clock = 1'b0;
	logic rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, slow = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, startAcq, acqBegin, acqEnd;
	logic [7:0] awaddr = 8'h0;
	logic [7:0] araddr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata, d;
	logic [31:0] seed = 32'hA00D6E9D;
	logic [1:0] bresp, rresp, resp;
	logic [CELL_COUNT*RES_W-1:0] aluCells = '0;
	logic [15:0] aluBlock = 16'h0, aluAux1 = 16'h0, aluAux2 = 16'h0, aluDiag = 16'h0;
	logic [15:0] alu [16];
	logic [15:0] shown [16];
	logic [15:0] measEn, pendTot, shownTot;
	logic [11:0] pendIdx, shownIdx;
	logic [13:0] expOv = 14'h0, expUv = 14'h0;
	logic expMm = 1'b0;
	int badCount = 0, testsRun = 0;
	// responses always accepted: bready and rready stay high
	result_transfer_and_alerts dut (.*, .wstrb(4'hF), .bready(1'b1), .rready(1'b1));
	acq_sequencer_model seq (.*);
	initial forever #2 clock = ~clock;
	function automatic logic [15:0] rnd();
		seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
		return seed[15:0];
	endfunction : rnd
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		testsRun++;
		if (seen !== exp) begin
			badCount++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw = 1'b0, w = 1'b0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clock);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			aw = aw | (awvalid && awready);
			w = w | (wvalid && wready);
		end
		do @(posedge clock); while (bvalid !== 1'b1);
		resp = bresp;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clock); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clock); while (rvalid !== 1'b1);
		d = rdata;
		resp = rresp;
	endtask : rd
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
		rd(a);
		chk(n, d, e);
	endtask : rdc
	// new arithmetic results, all cells at the set level for the tie case
	task automatic setAlu(input logic same);
		logic [CELL_COUNT*RES_W-1:0] c;
		for (int k = 0; k < 16; k++) alu[k] = same ? OVS : rnd() & 16'h3FFF;
		for (int k = 0; k < 12; k++) c[k*16 +: 16] = alu[k];
		aluCells <= c;
		aluBlock <= alu[12];
		aluAux1 <= alu[13];
		aluAux2 <= alu[14];
		aluDiag <= alu[15];
	endtask : setAlu
	// expected alerts and statistics
	task automatic evalAcq();
		logic [15:0] v, mn = 16'hFFFF, mx = 16'h0, tot = 16'h0;
		logic [3:0] iMn = 4'h0, iMx = 4'h0;
		for (int k = 0; k < 14; k++) begin
			v = alu[k < 12 ? k : k + 1];
			if (k < 12 && measEn[k]) begin
				tot = tot + v;
				iMn = (v <= mn) ? 4'(k + 1) : iMn;
				mn = (v <= mn) ? v : mn;
				iMx = (v >= mx) ? 4'(k + 1) : iMx;
				mx = (v >= mx) ? v : mx;
				expOv[k] = (v > OVS) ? 1'b1 : (v < OVC) ? 1'b0 : expOv[k];
				expUv[k] = (v < UVS) ? 1'b1 : (v > UVC) ? 1'b0 : expUv[k];
			end
			if (k >= 12 && measEn[k + 1]) begin
				expOv[k] = v > COLD;
				expUv[k] = v < HOT;
			end
		end
		if (iMx != 4'h0) begin
			pendTot = tot;
			pendIdx = {iMx, 4'h0, iMn};
			expMm = (mx - mn) > MMT;
		end
	endtask : evalAcq
	task automatic commit();
		shown = alu;
		shownTot = pendTot;
		shownIdx = pendIdx;
	endtask : commit
	task automatic start(input logic [31:0] ctrl);
		wr(CTRL_OFS, ctrl | 32'h11);
	endtask : start
	task automatic waitDone();
		do rd(STATUS_OFS); while (d[ST_DONE_BIT] !== 1'b1);
	endtask : waitDone
	task automatic checkAll();
		rdc(STATUS_OFS, {25'h0, |expOv[13:12], |expUv[13:12], expMm, |expUv[11:0],
			|expOv[11:0], 2'h3}, "status");
		rdc(OVFLAGS_OFS, {18'h0, expOv}, "over flags");
		rdc(UVFLAGS_OFS, {18'h0, expUv}, "under flags");
		rdc(ANYALERT_OFS, {20'h0, expOv[11:0] | expUv[11:0]}, "any alert");
		rdc(EXTREME_OFS, {20'h0, shownIdx}, "extreme index");
		rdc(TOTAL_OFS, {16'h0, shownTot}, "total");
		for (int k = 0; k < 16; k++)
			rdc(k < 12 ? CELL0_OFS + 8'(4 * k) : BLOCK_OFS + 8'(4 * k - 48),
				{16'h0, shown[k]}, "result");
		wr(STATUS_OFS, 32'h2);
	endtask : checkAll
	task automatic end_sim();
		if (badCount == 0 && testsRun > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	initial begin
		repeat (40000) @(posedge clock);
		badCount++;
		end_sim();
	end
	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rdc(MISMATCH_OFS, 32'hFFFC, "mismatch reset");
		wr(8'hFC, 32'h0);
		chk("unmapped write", {30'h0, resp}, {30'h0, RESP_SLVERR});
		rd(8'hFC);
		chk("unmapped read", {30'h0, resp}, {30'h0, RESP_SLVERR});
		measEn = 16'h6FFF;
		wr(MEASEN_OFS, {16'h0, measEn});
		wr(OVEN_OFS, 32'h3FFF);
		wr(UVEN_OFS, 32'h3FFF);
		wr(OVSET_OFS, {16'h0, OVS});
		wr(OVCLR_OFS, {16'h0, OVC});
		wr(UVSET_OFS, {16'h0, UVS});
		wr(UVCLR_OFS, {16'h0, UVC});
		wr(MISMATCH_OFS, {16'h0, MMT});
		wr(AUXHOT_OFS, {16'h0, HOT});
		wr(AUXCOLD_OFS, {16'h0, COLD});
		for (int i = 0; i < 8; i++) begin
			slow <= ^rnd();
			setAlu(i == 0);
			start(32'h0);
			waitDone();
			evalAcq();
			commit();
			checkAll();
		end
		// double buffering: copy at begin, move refused while busy
		slow <= 1'b1;
		start(32'h4);
		commit();
		for (int n = 0; n < 50 && acqBegin !== 1'b1; n++) @(posedge clock);
		setAlu(1'b0);
		wr(CTRL_OFS, 32'h16);
		rdc(CELL0_OFS, {16'h0, shown[0]}, "refused move");
		waitDone();
		evalAcq();
		checkAll();
		wr(CTRL_OFS, 32'h16);
		commit();
		checkAll();
		// no cells enabled: statistics hold, results still copied
		measEn = 16'h6000;
		wr(MEASEN_OFS, {16'h0, measEn});
		setAlu(1'b0);
		start(32'h0);
		rdc(CTRL_OFS, 32'h10, "control");
		waitDone();
		evalAcq();
		commit();
		checkAll();
		end_sim();
	end
endmodule : result_transfer_and_alerts_tb
bind result_transfer_and_alerts result_transfer_and_alerts_assertions chk (.*);
